/* File: common/regop_pkg.sv */
// shared constants and carriers for the register-operation execution block
package regop_pkg;

  // ----------------------------------------
  // encodings
  // ----------------------------------------
  localparam logic [5:0] complement_register_op = 6'h09; // 0010 01
  localparam logic [5:0] decrement_register_op  = 6'h03; // 0000 11
  localparam logic [5:0] decrement_skip_zero_op = 6'h0b; // 0010 11
  localparam int         op_hi                  = 11;
  localparam int         op_lo                  = 6;
  localparam int         dest_bit               = 5;
  localparam int         addr_hi                = 4;
  localparam logic [7:0] data_reset             = 8'h00;
  localparam logic [4:0] addr_reset             = 5'h00;
  localparam logic [11:0] instr_reset           = 12'h000;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic       valid;
    logic [4:0] addr;
    logic [7:0] data;
  } file_write_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } acc_write_s;

  typedef enum logic [0:0] {
    st_exec = 1'b0,
    st_flush = 1'b1
  } exec_state_e;

endpackage

/* File: verilog/regop_exec.sv */
// execution of complement, decrement and decrement-skip register operations
`timescale 1ns/1ns
`default_nettype none

// How it works
// [RULE1] complement op inverts addressed register, writes destination, sets zero, one cycle
// [RULE2] destination bit 0 writes accumulator, 1 writes back to register
// [RULE3] decrement op subtracts one, writes destination, sets zero, one cycle
// [RULE4] decrement-skip op subtracts one, writes destination, flags untouched
// [RULE5] zero result of decrement-skip drops prefetched word, runs no-op, two cycles
// [RULE6] skip realised by replacing prefetched word with no-op cycle
// [RULE7] low five bits address register file, bit five selects destination
module regop_exec (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  // instruction stream, one word per instruction cycle
  input  wire logic [11:0]           instr,
  // register file read port, registered from instr address
  output logic      [4:0]            read_addr,
  input  wire logic [7:0]            read_data,
  // result ports
  output regop_pkg::file_write_s     file_write,
  output regop_pkg::acc_write_s      acc_write,
  output logic                       zero_we,
  output logic                       zero_value,
  output logic                       skip_nop,
  output logic                       busy_second_cycle
);

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_meta;
  logic rst_sync;

  logic next_rst_meta;
  logic next_rst_sync;

  // async assert, clean release two edges later
  always_comb begin
    next_rst_meta = 1'b1;
    next_rst_sync = rst_meta;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= next_rst_meta;
      rst_sync <= next_rst_sync;
    end
  end

  // ----------------------------------------
  // decode
  // ----------------------------------------
  logic [5:0] opcode;
  logic       dest;
  logic [4:0] faddr;
  logic [7:0] result;
  logic       is_com;
  logic       is_dec;
  logic       is_dsz;
  logic       active;

  regop_pkg::exec_state_e state;
  regop_pkg::exec_state_e next_state;
  regop_pkg::file_write_s next_file_write;
  regop_pkg::acc_write_s  next_acc_write;
  logic                   next_zero_we;
  logic                   next_zero_value;
  logic                   next_skip_nop;
  logic                   next_busy;
  logic [4:0]             next_read_addr;

  logic                   zero_result;

  always_comb begin
    opcode = instr[regop_pkg::op_hi:regop_pkg::op_lo];
    // [RULE7] address and destination fields
    dest   = instr[regop_pkg::dest_bit];
    faddr  = instr[regop_pkg::addr_hi:0];
  end

  // the word after a taken skip is discarded, so nothing decodes then
  always_comb begin
    active = (state == regop_pkg::st_exec);
    is_com = 1'b0;
    is_dec = 1'b0;
    is_dsz = 1'b0;
    if (active) begin
      case (opcode)
        regop_pkg::complement_register_op: begin
          is_com = 1'b1;
        end
        regop_pkg::decrement_register_op: begin
          is_dec = 1'b1;
        end
        regop_pkg::decrement_skip_zero_op: begin
          is_dsz = 1'b1;
        end
        default: begin
          // other opcodes belong to other units
          is_com = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // arithmetic
  // ----------------------------------------
  always_comb begin
    // [RULE1] inverse of operand
    if (is_com) begin
      result = ~read_data;
    end else begin
      // [RULE3] subtract one, wraps 00 to ff
      result = read_data - 8'h01;
    end
    zero_result = (result == regop_pkg::data_reset);
  end

  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  always_comb begin
    next_state    = regop_pkg::st_exec;
    next_busy     = 1'b0;
    next_skip_nop = 1'b0;
    case (state)
      regop_pkg::st_exec: begin
        // [RULE5] zero result forces a second cycle
        if (is_dsz && zero_result) begin
          next_state = regop_pkg::st_flush;
          next_busy  = 1'b1;
        end
      end
      regop_pkg::st_flush: begin
        // [RULE6] prefetched word replaced by a no-op
        next_skip_nop = 1'b1;
        next_state    = regop_pkg::st_exec;
      end
      default: begin
        next_state = regop_pkg::st_exec;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      state             <= regop_pkg::st_exec;
      busy_second_cycle <= 1'b0;
      skip_nop          <= 1'b0;
    end else begin
      state             <= next_state;
      busy_second_cycle <= next_busy;
      skip_nop          <= next_skip_nop;
    end
  end

  // ----------------------------------------
  // result steering
  // ----------------------------------------
  always_comb begin
    // late echo only; the operand must already stand on read_data
    next_read_addr  = faddr;
    next_file_write = '0;
    next_acc_write  = '0;
    if (is_com || is_dec || is_dsz) begin
      // [RULE2] steer result by destination bit
      if (dest) begin
        next_file_write.valid = 1'b1;
        next_file_write.addr  = faddr;
        next_file_write.data  = result;
      end else begin
        next_acc_write.valid = 1'b1;
        next_acc_write.data  = result;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      file_write <= '0;
      acc_write  <= '0;
      read_addr  <= regop_pkg::addr_reset;
    end else begin
      file_write <= next_file_write;
      acc_write  <= next_acc_write;
      read_addr  <= next_read_addr;
    end
  end

  // ----------------------------------------
  // zero flag update
  // ----------------------------------------
  always_comb begin
    next_zero_we    = 1'b0;
    next_zero_value = 1'b0;
    // [RULE4] skip variant leaves zero flag alone
    if (is_com || is_dec) begin
      next_zero_we    = 1'b1;
      next_zero_value = zero_result;
    end
  end

  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      zero_we    <= 1'b0;
      zero_value <= 1'b0;
    end else begin
      zero_we    <= next_zero_we;
      zero_value <= next_zero_value;
    end
  end

endmodule

`default_nettype wire

/* File: test/regop_exec_props.sv */
// assertions on the regop_exec ports
`timescale 1ns/1ns
`default_nettype none
module regop_exec_props (
  input wire logic                   clk,
  input wire logic                   reset_n,
  input wire logic [11:0]            instr,
  input wire logic [7:0]             read_data,
  input wire regop_pkg::file_write_s file_write,
  input wire regop_pkg::acc_write_s  acc_write,
  input wire logic                   zero_we,
  input wire logic                   zero_value,
  input wire logic                   skip_nop,
  input wire logic                   busy_second_cycle
);
  logic       cm, dc, dz;
  logic [7:0] res;
  // a word arriving during the flush cycle is ignored
  assign cm = !busy_second_cycle && instr[11:6] == regop_pkg::complement_register_op;
  assign dc = !busy_second_cycle && instr[11:6] == regop_pkg::decrement_register_op;
  assign dz = !busy_second_cycle && instr[11:6] == regop_pkg::decrement_skip_zero_op;
  assign res = file_write.valid ? file_write.data : acc_write.data;
  default clocking @(posedge clk); endclocking
  logic [2:0] rel;
  // the design leaves reset on the second edge after reset_n rises; checks arm on the third
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rel <= 3'h0;
    end else begin
      rel <= {rel[1:0], 1'b1};
    end
  end
  default disable iff (!rel[2]);
  sequence flushed;
    busy_second_cycle ##1 skip_nop && !file_write.valid && !acc_write.valid;
  endsequence
  chk_comp_value: assert property (cm |=> zero_we && zero_value == !res &&
    res == ~$past(read_data)) else $error("complement wrong");
  chk_dest_route: assert property (cm || dc || dz |=>
    file_write.valid == $past(instr[5]) && acc_write.valid != $past(instr[5]))
    else $error("destination wrong");
  chk_dec_value: assert property (dc |=> zero_we && zero_value == !res &&
    res == $past(read_data) - 8'h01) else $error("decrement wrong");
  chk_skip_flags: assert property (dz |=> !zero_we &&
    res == $past(read_data) - 8'h01) else $error("skip decrement wrong");
  chk_skip_drop: assert property (dz && read_data == 8'h01 |=> flushed)
    else $error("skip not taken");
  chk_no_skip: assert property (dz && read_data != 8'h01 |=>
    !busy_second_cycle ##1 !skip_nop) else $error("skip wrongly taken");
  chk_file_addr: assert property ((cm || dc || dz) && instr[5] |=>
    file_write.addr == $past(instr[4:0])) else $error("address wrong");
endmodule
bind regop_exec regop_exec_props chk_u (
  .clk               (clk),
  .reset_n           (reset_n),
  .instr             (instr),
  .read_data         (read_data),
  .file_write        (file_write),
  .acc_write         (acc_write),
  .zero_we           (zero_we),
  .zero_value        (zero_value),
  .skip_nop          (skip_nop),
  .busy_second_cycle (busy_second_cycle)
);
`default_nettype wire

/* File: test/tb.sv */
// self-checking bench for regop_exec
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic                   clk = 1'b0;
  logic                   reset_n = 1'b0;
  logic [11:0]            instr = 12'h000;
  logic [7:0]             read_data = 8'h00;
  regop_pkg::file_write_s file_write;
  regop_pkg::acc_write_s  acc_write;
  logic                   zero_we, zero_value, skip_nop, busy_second_cycle;
  logic [4:0]             read_addr;
  localparam logic [5:0]  com_op = regop_pkg::complement_register_op;
  localparam logic [5:0]  dec_op = regop_pkg::decrement_register_op;
  localparam logic [5:0]  dsz_op = regop_pkg::decrement_skip_zero_op;
  int                     miscompares = 0, checks = 0, cycles = 0;
  wire logic [26:0]       outv = {acc_write, file_write, zero_we, zero_value, skip_nop,
                                  busy_second_cycle};
  regop_exec dut_u (
    .clk               (clk),
    .reset_n           (reset_n),
    .instr             (instr),
    .read_addr         (read_addr),
    .read_data         (read_data),
    .file_write        (file_write),
    .acc_write         (acc_write),
    .zero_we           (zero_we),
    .zero_value        (zero_value),
    .skip_nop          (skip_nop),
    .busy_second_cycle (busy_second_cycle)
  );
  always #5 clk = ~clk;
  task automatic complete_run;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string what, input logic [26:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // nx is the word presented in the cycle after w
  task automatic step(input logic [11:0] w, nx, input logic [7:0] v, input logic [26:0] e);
    @(posedge clk);
    instr     <= w;
    read_data <= v;
    @(posedge clk);
    instr <= nx;
    @(negedge clk);
    chk("outputs", outv, e);
    chk("read_addr", {22'h0, read_addr}, {22'h0, w[4:0]});
  endtask
  task automatic t_comp;
    step({com_op, 6'h05}, 12'h000, 8'h13, {1'b1, 8'hec, 14'h0, 4'h8});
    step({com_op, 6'h3f}, 12'h000, 8'hff, {9'h0, 6'h3f, 8'h00, 4'hc});
  endtask
  task automatic t_dec;
    step({dec_op, 6'h20}, 12'h000, 8'h01, {9'h0, 6'h20, 8'h00, 4'hc});
    step({dec_op, 6'h0a}, 12'h000, 8'h00, {1'b1, 8'hff, 14'h0, 4'h8});
  endtask
  // neighbours of the patterns must leave every output but read_addr quiet
  task automatic t_other;
    step({6'h08, 6'h25}, 12'h000, 8'h01, 27'h0);
    step({6'h0a, 6'h25}, 12'h000, 8'h01, 27'h0);
  endtask
  task automatic t_skip;
    step({dsz_op, 6'h07}, 12'h000, 8'h05, {1'b1, 8'h04, 18'h0});
    step({dsz_op, 6'h29}, {com_op, 6'h05}, 8'h01, {9'h0, 6'h29, 8'h00, 4'h1});
    @(negedge clk);
    chk("flush", outv, {23'h0, 4'h2});
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
  end
  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    fork
      begin
        t_comp();
        t_dec();
        t_other();
        t_skip();
      end
      begin
        wait (cycles == 400);
        miscompares++;
      end
    join_any
    disable fork;
    complete_run();
  end
endmodule
`default_nettype wire
